// *** rtl/itd_engine.sv ***
// isochronous transmit descriptor engine with apb registers
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`include "itd_cfg.svh"
module itd_engine (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cycle_start,
    input wire logic cycle_missed,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic fifo_valid,
    input wire logic fifo_ready,
    output logic [31:0] fifo_data,
    output logic fifo_last,
    output itd_pkg::itd_chan_t fifo_channel
);
    import itd_pkg::*;

    localparam int N = `ITD_NCTX;

    function automatic itd_kind_t kind_of(input logic [3:0] c,
                                          input logic [2:0] k);
        kind_of = K_BAD;
        if (c == `ITD_CMD_MORE && k == `ITD_KEY_DATA) begin
            kind_of = K_MORE;
        end else if (c == `ITD_CMD_MORE && k == `ITD_KEY_IMM) begin
            kind_of = K_MORE_IMM;
        end else if (c == `ITD_CMD_LAST && k == `ITD_KEY_DATA) begin
            kind_of = K_LAST;
        end else if (c == `ITD_CMD_LAST && k == `ITD_KEY_IMM) begin
            kind_of = K_LAST_IMM;
        end else if (c == `ITD_CMD_STORE && k == `ITD_KEY_IMM) begin
            kind_of = K_STORE;
        end
    endfunction

    // per-context state
    logic [N-1:0] run_q;
    logic [N-1:0] dead_q;
    logic [N-1:0] pend_q;
    logic [N-1:0] miss_q;
    logic [27:0] ptr_q [N];
    logic [3:0] z_q [N];
    itd_chan_t chan_q [N];

    // engine state
    itd_state_t st_q;
    logic [1:0] cx_q;
    logic [27:0] dp_q;
    logic [2:0] qi_q;
    logic [31:0] dq_q [6];
    logic first_q;
    logic hdr_q;
    logic hsel_q;
    logic islast_q;
    logic [31:0] ba_q;
    logic [15:0] rem_q;
    logic [31:0] word_q;
    logic [31:0] pack_q;
    logic [2:0] pk_q;
    logic pv_q;
    logic [38:0] pd_q;
    logic upd_q;
    logic [27:0] uptr_q;
    logic [3:0] uz_q;
    logic ustop_q;
    logic udead_q;
    logic pick_q;
    logic clrmiss_q;
    logic buf_ready;
    logic [38:0] buf_out;
    logic [N-1:0] pick_vec;
    logic [N-1:0] miss_vec;

    // apb decode
    logic acc;
    logic [1:0] a_cx;
    logic hit_ctrl;
    logic hit_ptr;
    logic [31:0] rd_d;
    assign acc = psel && penable && !pready;
    assign a_cx = paddr[5:4];
    assign hit_ctrl = paddr[7:6] == 2'b00 && paddr[3:0] == `ITD_OFF_CTRL;
    assign hit_ptr = paddr[7:6] == 2'b00 && paddr[3:0] == `ITD_OFF_PTR;

    always_comb begin
        rd_d = `ITD_RST_WORD;
        if (hit_ctrl) begin
            rd_d[`ITD_CTRL_RUN] = run_q[a_cx];
            rd_d[`ITD_CTRL_ACT] = (st_q != ST_IDLE) && (cx_q == a_cx);
            rd_d[`ITD_CTRL_DEAD] = dead_q[a_cx];
            rd_d[`ITD_CHAN_LSB +: 6] = chan_q[a_cx];
        end else if (hit_ptr) begin
            rd_d = {ptr_q[a_cx], z_q[a_cx]};
        end
    end

    // one wait state: pready is high in the second access cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `ITD_RST_WORD;
        end else begin
            pready <= acc;
            pslverr <= acc && !(hit_ctrl || hit_ptr);
            if (acc && !pwrite) begin
                prdata <= rd_d;
            end
        end
    end

    // context registers, one copy per context
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ctx
            logic wr_here;
            assign wr_here = psel && penable && pready && pwrite && a_cx == g;
            assign pick_vec[g] = pick_q && cx_q == g;
            assign miss_vec[g] = clrmiss_q && cx_q == g;
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    run_q[g] <= 1'b0;
                    dead_q[g] <= 1'b0;
                    chan_q[g] <= '0;
                    ptr_q[g] <= `ITD_RST_PTR;
                    z_q[g] <= 4'h0;
                end else begin
                    if (upd_q && cx_q == g) begin
                        ptr_q[g] <= uptr_q;
                        z_q[g] <= uz_q;
                        if (ustop_q) begin
                            run_q[g] <= 1'b0;
                        end
                        if (udead_q) begin
                            dead_q[g] <= 1'b1;
                        end
                    end
                    if (wr_here && hit_ctrl) begin
                        run_q[g] <= pwdata[`ITD_CTRL_RUN];
                        chan_q[g] <= pwdata[`ITD_CHAN_LSB +: 6];
                        if (pwdata[`ITD_CTRL_RUN]) begin
                            dead_q[g] <= 1'b0;
                        end
                    end
                    if (wr_here && hit_ptr) begin
                        ptr_q[g] <= pwdata[31:4];
                        z_q[g] <= pwdata[3:0];
                    end
                end
            end
            // set wins over clear for both event flags
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    pend_q[g] <= 1'b0;
                    miss_q[g] <= 1'b0;
                end else begin
                    if (cycle_start && run_q[g]) begin
                        pend_q[g] <= 1'b1;
                    end else if (pick_vec[g]) begin
                        pend_q[g] <= 1'b0;
                    end
                    if (cycle_missed && run_q[g]) begin
                        miss_q[g] <= 1'b1;
                    end else if (miss_vec[g]) begin
                        miss_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // lowest pending context is served first
    logic [1:0] nxt_cx;
    logic any_pend;
    always_comb begin
        nxt_cx = 2'd0;
        any_pend = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_q[i] && run_q[i]) begin
                nxt_cx = 2'(i);
                any_pend = 1'b1;
            end
        end
    end

    logic [7:0] cur_byte;
    logic [15:0] cnt;
    assign cur_byte = word_q[8 * (3 - ba_q[1:0]) +: 8];
    assign cnt = dq_q[0][15:0];

    // descriptor fetch and packet assembly
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            cx_q <= 2'd0;
            dp_q <= `ITD_RST_PTR;
            qi_q <= 3'd0;
            first_q <= 1'b0;
            hdr_q <= 1'b0;
            hsel_q <= 1'b0;
            islast_q <= 1'b0;
            ba_q <= `ITD_RST_WORD;
            rem_q <= 16'h0000;
            word_q <= `ITD_RST_WORD;
            pack_q <= `ITD_RST_WORD;
            pk_q <= 3'd0;
            pv_q <= 1'b0;
            pd_q <= '0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= `ITD_RST_WORD;
            mem_wdata <= `ITD_RST_WORD;
            upd_q <= 1'b0;
            uptr_q <= `ITD_RST_PTR;
            uz_q <= 4'h0;
            ustop_q <= 1'b0;
            udead_q <= 1'b0;
            pick_q <= 1'b0;
            clrmiss_q <= 1'b0;
        end else begin
            pick_q <= 1'b0;
            clrmiss_q <= 1'b0;
            upd_q <= 1'b0;
            if (pv_q && buf_ready) begin
                pv_q <= 1'b0;
            end
            case (st_q)
                ST_IDLE: begin
                    if (any_pend && !upd_q) begin
                        cx_q <= nxt_cx;
                        dp_q <= ptr_q[nxt_cx];
                        qi_q <= 3'd0;
                        first_q <= 1'b1;
                        hdr_q <= 1'b0;
                        pk_q <= 3'd0;
                        pick_q <= 1'b1;
                        st_q <= ST_RDQ;
                    end
                end
                ST_RDQ: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= {dp_q, `ITD_BLK_BYTES} +
                                    {27'h0, qi_q, 2'b00};
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        dq_q[qi_q] <= mem_rdata;
                        qi_q <= qi_q + 3'd1;
                        if (qi_q == `ITD_Q_LAST_HDR) begin
                            hsel_q <= 1'b0;
                            st_q <= ST_HDR;
                        end else if (qi_q == `ITD_Q_LAST_DESC && !hdr_q) begin
                            st_q <= ST_DEC;
                        end
                    end
                end
                ST_DEC: begin
                    if (first_q && miss_q[cx_q]) begin
                        // skip target lives in the block's first one
                        clrmiss_q <= 1'b1;
                        upd_q <= 1'b1;
                        uptr_q <= dq_q[3][31:4];
                        uz_q <= dq_q[3][3:0];
                        ustop_q <= dq_q[3][3:0] == 4'h0;
                        udead_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end else begin
                        case (kind_of(dq_q[0][31:28], dq_q[0][26:24]))
                            K_MORE, K_LAST: begin
                                ba_q <= dq_q[1];
                                rem_q <= cnt;
                                islast_q <= dq_q[0][28];
                                if (dq_q[0][28] && cnt == 16'h0000) begin
                                    st_q <= ST_UPD;
                                end else begin
                                    st_q <= ST_DRD;
                                end
                            end
                            K_MORE_IMM, K_LAST_IMM: begin
                                // count is taken as 8 whatever it says
                                hdr_q <= 1'b1;
                                qi_q <= `ITD_Q_HDR0;
                                islast_q <= dq_q[0][28];
                                st_q <= ST_RDQ;
                            end
                            K_STORE: begin
                                st_q <= ST_STORE;
                            end
                            default: begin
                                upd_q <= 1'b1;
                                uptr_q <= dp_q;
                                uz_q <= z_q[cx_q];
                                ustop_q <= 1'b1;
                                udead_q <= 1'b1;
                                st_q <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_HDR: begin
                    if (!pv_q) begin
                        pv_q <= 1'b1;
                        pd_q <= {chan_q[cx_q], hsel_q && islast_q,
                                 dq_q[{2'b10, hsel_q}]};
                        hsel_q <= 1'b1;
                        if (hsel_q) begin
                            if (islast_q) begin
                                st_q <= ST_UPD;
                            end else begin
                                dp_q <= dp_q + 28'd2;
                                qi_q <= 3'd0;
                                first_q <= 1'b0;
                                hdr_q <= 1'b0;
                                st_q <= ST_RDQ;
                            end
                        end
                    end
                end
                ST_DRD: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= {ba_q[31:2], 2'b00};
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        word_q <= mem_rdata;
                        st_q <= ST_DBY;
                    end
                end
                ST_DBY: begin
                    if (pv_q) begin
                        st_q <= ST_DBY;
                    end else if (pk_q == 3'd4) begin
                        pv_q <= 1'b1;
                        pd_q <= {chan_q[cx_q],
                                 islast_q && rem_q == 16'h0000, pack_q};
                        pk_q <= 3'd0;
                    end else if (rem_q == 16'h0000) begin
                        if (islast_q && pk_q != 3'd0) begin
                            // tail of the packet is zero padded
                            pv_q <= 1'b1;
                            pd_q <= {chan_q[cx_q], 1'b1,
                                     pack_q << (8 * (4 - pk_q))};
                            pk_q <= 3'd0;
                        end
                        if (islast_q) begin
                            st_q <= ST_UPD;
                        end else begin
                            // a partial word carries into the next one
                            dp_q <= dp_q + 28'd1;
                            qi_q <= 3'd0;
                            first_q <= 1'b0;
                            st_q <= ST_RDQ;
                        end
                    end else begin
                        pack_q <= {pack_q[23:0], cur_byte};
                        pk_q <= pk_q + 3'd1;
                        ba_q <= ba_q + 32'd1;
                        rem_q <= rem_q - 16'd1;
                        if (ba_q[1:0] == 2'b11 && rem_q != 16'd1) begin
                            st_q <= ST_DRD;
                        end
                    end
                end
                ST_STORE: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= dq_q[1];
                        mem_wdata <= dq_q[2];
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        dp_q <= dp_q + 28'd1;
                        qi_q <= 3'd0;
                        first_q <= 1'b0;
                        st_q <= ST_RDQ;
                    end
                end
                ST_UPD: begin
                    if (!pv_q) begin
                        upd_q <= 1'b1;
                        uptr_q <= dq_q[2][31:4];
                        uz_q <= dq_q[2][3:0];
                        ustop_q <= dq_q[2][3:0] == 4'h0;
                        udead_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    itd_buf2 #(
        .W(39)
    ) u_buf (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(pv_q),
        .in_ready(buf_ready),
        .in_data(pd_q),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(buf_out)
    );

    assign fifo_data = buf_out[31:0];
    assign fifo_last = buf_out[32];
    assign fifo_channel = buf_out[38:33];
endmodule

// *** rtl/itd_cfg.svh ***
// constants of the isochronous transmit descriptor engine
// Summary of operation
// - four transmit contexts are built, within the range of 4 to 32.
// - each context carries one channel number onto every word it sends.
// - descriptors sit on 16-byte boundaries and are fetched as such.
// - command 0 with key 0 is a data fragment; branch must be zero.
// - command 0 with key 2 is an inline header; its count must be 8, but the engine does not check it and takes any count as 8.
// - a fragment reads its 16-bit count of bytes from any byte address.
// - the two inline header quadlets go to the fifo with no buffer read.
// - an inline header descriptor that is not final steps two 16-byte blocks.
// - a missed cycle resumes at the skip target of a block's first one.
// - a skip count of 1 to 8 sizes the skip block; zero stops the context.
// - a final descriptor closes the packet, except a final fragment with count 0, which marks no word last; nothing more is appended.
// - a store descriptor writes one quadlet to the address it gives.
`ifndef ITD_CFG_SVH
`define ITD_CFG_SVH
`define ITD_NCTX 4
`define ITD_CTX_STRIDE 8'h10
`define ITD_OFF_CTRL 4'h0
`define ITD_OFF_PTR 4'h4
`define ITD_CTRL_RUN 0
`define ITD_CTRL_ACT 1
`define ITD_CTRL_DEAD 2
`define ITD_CHAN_LSB 8
`define ITD_CMD_MORE 4'h0
`define ITD_CMD_LAST 4'h1
`define ITD_CMD_STORE 4'h8
`define ITD_KEY_DATA 3'h0
`define ITD_KEY_IMM 3'h2
`define ITD_CNT_HDR 16'h0008
`define ITD_BLK_BYTES 4'h0
`define ITD_Q_LAST_DESC 3'h3
`define ITD_Q_LAST_HDR 3'h5
`define ITD_Q_HDR0 3'h4
`define ITD_RST_PTR 28'h000_0000
`define ITD_RST_WORD 32'h0000_0000
`endif

// *** rtl/itd_pkg.sv ***
// types of the isochronous transmit descriptor engine
package itd_pkg;
    typedef enum {
        ST_IDLE, ST_RDQ, ST_DEC, ST_HDR, ST_DRD, ST_DBY,
        ST_STORE, ST_UPD
    } itd_state_t;
    typedef enum {
        K_MORE, K_MORE_IMM, K_LAST, K_LAST_IMM, K_STORE, K_BAD
    } itd_kind_t;
    typedef logic [5:0] itd_chan_t;
endpackage

// *** rtl/itd_buf2.sv ***
// two-entry valid/ready buffer in front of the transmit fifo
module itd_buf2 #(
    parameter int W = 39
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [2];
    logic [1:0] cnt_q;
    logic rd_q;
    logic wr_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 2'd0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'd1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'd1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// *** verif/itd_engine_checker.sv ***
// port assertions for the transmit descriptor engine
module itd_engine_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic fifo_valid,
    input wire logic fifo_ready,
    input wire logic [31:0] fifo_data,
    input wire logic fifo_last,
    input wire itd_pkg::itd_chan_t fifo_channel
);
    import itd_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_wait;
        mem_req && !mem_ack;
    endsequence
    a_apb_one_wait: assert property (s_access |=> pready)
        else $error("apb answer late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_map_err: assert property (pready |->
        pslverr == (paddr >= 8'h40 || paddr[3] || paddr[1:0] != 2'b00))
        else $error("pslverr wrong for address");
    a_req_holds: assert property (s_wait |=> mem_req && $stable(mem_addr)
        && $stable(mem_we) && $stable(mem_wdata))
        else $error("request moved before ack");
    a_req_drops: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request kept after ack");
    a_fetch_aligned: assert property (
        mem_req && !mem_we |-> mem_addr[1:0] == 2'b00)
        else $error("unaligned memory read");
    a_store_once: assert property (
        mem_we && mem_ack |=> !mem_req ##1 !(mem_req && mem_we))
        else $error("second store write");
    a_fifo_holds: assert property (fifo_valid && !fifo_ready |=>
        fifo_valid && $stable(fifo_data) && $stable(fifo_last)
        && $stable(fifo_channel))
        else $error("fifo word moved in stall");
endmodule

bind itd_engine itd_engine_checker itd_engine_checker_inst (
    .clock, .rst_n, .psel, .penable, .paddr, .pready, .pslverr,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .fifo_valid, .fifo_ready, .fifo_data, .fifo_last, .fifo_channel
);

// *** verif/itd_host_mem.sv ***
// host memory model answering the engine's memory requests
module itd_host_mem (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] lat,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] words [0:255];
    logic [3:0] cnt_q;
    // idle read data flips so a stale word never passes for an answer
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            cnt_q <= 4'h0;
            mem_rdata <= 32'h0000_0000;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q >= lat) begin
                    cnt_q <= 4'h0;
                    mem_ack <= 1'b1;
                    if (mem_we)
                        words[mem_addr[9:2]] <= mem_wdata;
                    else
                        mem_rdata <= words[mem_addr[9:2]];
                end
            end
        end
    end
endmodule

// *** verif/itd_engine_tb.sv ***
// self-checking bench for the transmit descriptor engine
module itd_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import itd_pkg::*;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic cycle_start = 0, cycle_missed = 0, fifo_ready = 1;
    logic [7:0] paddr = 8'h00;
    logic [3:0] lat = 4'h0;
    logic [31:0] pwdata = 32'h0000_0000, prdata, mem_addr, mem_wdata;
    logic [31:0] mem_rdata, fifo_data, r;
    logic pready, pslverr, fifo_valid, fifo_last, mem_req, mem_we;
    logic mem_ack, e;
    itd_chan_t fifo_channel;
    logic [38:0] got[$];
    int num_errors = 0, num_checks = 0;
    localparam logic [31:0] H0 = 32'h0008_05a0, H1 = 32'hc0de_0001;

    always #4 clock = ~clock;

    itd_engine itd_engine_inst (.clock, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .cycle_start,
        .cycle_missed, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata, .fifo_valid, .fifo_ready, .fifo_data, .fifo_last,
        .fifo_channel);
    itd_host_mem itd_host_mem_inst (.clock, .rst_n, .lat, .mem_req,
        .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

    always @(posedge clock)
        if (fifo_valid === 1'b1 && fifo_ready === 1'b1)
            got.push_back({fifo_last, fifo_channel, fifo_data});

    function automatic logic [7:0] pat(logic [9:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction

    function automatic logic [31:0] q0(logic [3:0] c, logic [2:0] k,
                                       logic [15:0] n);
        return {c, 1'b0, k, 8'h00, n};
    endfunction

    task automatic chk(string what, logic [38:0] seen, logic [38:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20)
            num_errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_mem(logic [9:0] a, logic [31:0] w0, w1, w2, w3);
        itd_host_mem_inst.words[a[9:2]] = w0;
        itd_host_mem_inst.words[a[9:2] + 8'h01] = w1;
        itd_host_mem_inst.words[a[9:2] + 8'h02] = w2;
        itd_host_mem_inst.words[a[9:2] + 8'h03] = w3;
    endtask

    // polls active: no done strobe
    task automatic go(logic [7:0] base, logic miss);
        int n;
        n = 0;
        @(posedge clock);
        cycle_missed <= miss;
        @(posedge clock);
        cycle_missed <= 1'b0;
        cycle_start <= 1'b1;
        @(posedge clock);
        cycle_start <= 1'b0;
        while (mem_req !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        do apb(1'b0, base, 32'h0); while (r[1] !== 1'b0 && ++n < 150);
        if (n >= 150)
            num_errors++;
    endtask

    task automatic run(logic [7:0] b, logic [31:0] p, c, logic miss);
        apb(1'b1, b + 8'h04, p);
        apb(1'b1, b, c);
        go(b, miss);
    endtask

    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl0 reset", r, 32'h0000_0000);
        apb(1'b1, 8'h30, 32'h0000_3f00);
        apb(1'b0, 8'h30, 32'h0);
        chk("ctrl3 channel", r, 32'h0000_3f00);
        apb(1'b0, 8'h34, 32'h0);
        chk("ptr3 reset", r, 32'h0000_0000);
        apb(1'b1, 8'h40, 32'hffff_ffff);
        chk("ctx4 err", e, 1'b1);
        apb(1'b0, 8'h28, 32'h0);
        chk("gap read", {e, r}, {1'b1, 32'h0000_0000});
    endtask

    task automatic t_packet();
        logic [38:0] x[5];
        x = '{{7'h05, H0}, {7'h05, H1},
            {7'h05, pat(10'h301), pat(10'h302), pat(10'h303), pat(10'h203)},
            {7'h05, pat(10'h204), pat(10'h205), pat(10'h206), pat(10'h207)},
            {7'h45, pat(10'h208), 24'h00_0000}};
        wr_mem(10'h040, q0(4'h0, 3'h2, 16'h0008), 0, 0, 0);
        wr_mem(10'h050, H0, H1, 0, 0);
        wr_mem(10'h060, q0(4'h0, 3'h0, 16'h0003), 32'h301, 0, 0);
        wr_mem(10'h070, q0(4'h1, 3'h0, 16'h0006), 32'h203, 0, 0);
        got.delete();
        lat <= 4'h3;
        fifo_ready <= 1'b0;
        fork
            begin
                repeat (40) @(posedge clock);
                fifo_ready <= 1'b1;
            end
        join_none
        run(8'h00, 32'h0000_0044, 32'h0000_0501, 1'b0);
        chk("pkt words", got.size(), 5);
        for (int i = 0; i < 5; i++)
            chk("pkt word", got[i], x[i]);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl0 stop", r, 32'h0000_0500);
        lat <= 4'h0;
    endtask

    task automatic t_hdr_only();
        wr_mem(10'h080, q0(4'h1, 3'h2, 16'h0008), 0, 0, 32'hc2);
        wr_mem(10'h090, H0, H1, 0, 0);
        got.delete();
        run(8'h10, 32'h0000_0082, 32'h0000_0101, 1'b0);
        chk("hdr count", got.size(), 2);
        chk("hdr0", got[0], {7'h01, H0});
        chk("hdr1", got[1], {7'h41, H1});
    endtask

    task automatic t_missed();
        wr_mem(10'h0c0, q0(4'h8, 3'h2, 16'h0), 32'h3f0, 32'hcafe_f00d, 0);
        wr_mem(10'h0d0, q0(4'h1, 3'h0, 16'h0), 0, 0, 0);
        itd_host_mem_inst.words[8'hfc] = 32'h0000_0000;
        got.delete();
        run(8'h10, 32'h0000_0082, 32'h0000_0101, 1'b1);
        apb(1'b0, 8'h14, 32'h0);
        chk("skip ptr", r, 32'h0000_00c2);
        go(8'h10, 1'b0);
        chk("store", itd_host_mem_inst.words[8'hfc], 32'hcafe_f00d);
        chk("no data", got.size(), 0);
        apb(1'b0, 8'h10, 32'h0);
        chk("ctrl1 stop", r, 32'h0000_0100);
    endtask

    task automatic t_bad();
        wr_mem(10'h0e0, 32'h5000_0000, 0, 0, 0);
        run(8'h20, 32'h0000_00e1, 32'h0000_0201, 1'b0);
        apb(1'b0, 8'h20, 32'h0);
        chk("dead", r, 32'h0000_0204);
    endtask

    initial begin
        for (int a = 'h200; a < 'h400; a += 4)
            itd_host_mem_inst.words[a >> 2] = {pat(10'(a)), pat(10'(a + 1)),
                pat(10'(a + 2)), pat(10'(a + 3))};
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_packet();
        t_hdr_only();
        t_missed();
        t_bad();
        results();
    end

    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule
